// File: src/dsdc_pkg.sv
package dsdc_pkg;
    // ******
    // Register indices; byte address is four times index.
    // ******
    localparam logic [9:0] IDX_FREQ_SRC = 10'h014;
    localparam logic [9:0] IDX_RUN_SRC = 10'h015;
    localparam logic [9:0] IDX_STOP = 10'h016;
    localparam logic [9:0] IDX_DIR = 10'h017;
    localparam logic [9:0] IDX_KP_LATCH = 10'h018;
    localparam logic [9:0] IDX_FORMAT = 10'h019;
    localparam logic [9:0] IDX_USER_MAX = 10'h01a;
    localparam logic [9:0] IDX_USER_VAL = 10'h01b;
    localparam logic [9:0] IDX_POLICY = 10'h01d;
    localparam logic [9:0] IDX_STATUS = 10'h020;
    // Reset values.
    localparam logic [15:0] RST_FREQ_SRC = 16'h0000;
    localparam logic [15:0] RST_RUN_SRC = 16'h0000;
    localparam logic [15:0] RST_STOP = 16'h0000;
    localparam logic [15:0] RST_DIR = 16'h0000;
    localparam logic [15:0] RST_FORMAT = 16'h0000;
    localparam logic [15:0] RST_USER_MAX = 16'h0000;
    localparam logic [15:0] RST_POLICY = 16'h0004;
    // Field codes.
    localparam logic [15:0] SRC_KEYPAD = 16'h0000;
    localparam logic [15:0] SRC_SERIAL_FREQ = 16'h0001;
    localparam logic [15:0] RUN_SRC_MAX = 16'h0002;
    localparam logic [15:0] STOP_RAMP = 16'h0000;
    localparam logic [15:0] STOP_COAST = 16'h0001;
    localparam logic [15:0] STOP_POSN = 16'h0002;
    localparam logic [15:0] DIR_NO_REV = 16'h0001;
    localparam logic [15:0] DIR_NO_FWD = 16'h0002;
    localparam logic [15:0] POLICY_HOA = 16'h0000;
    localparam logic [15:0] POLICY_MAX = 16'h0004;
    localparam int FMT_DEC_LSB = 0;
    localparam int FMT_DEC_MSB = 3;
    localparam int FMT_UNIT_LSB = 4;
    localparam int FMT_UNIT_MSB = 15;
    localparam logic [3:0] FMT_DEC_MAX = 4'h3;
    // Deceleration tick timing.
    localparam int CLK_MHZ = 100;
    localparam int DECEL_TICK_US = 1000;
    localparam int DECEL_TICK_CYCLES = CLK_MHZ * DECEL_TICK_US;
    // Stop sequencer states.
    typedef enum logic [3:0] {
        DSDC_IDLE = 4'b0001,
        DSDC_RUN = 4'b0010,
        DSDC_RAMP = 4'b0100,
        DSDC_POSN = 4'b1000
    } dsdc_stop_state_t;
endpackage

// File: src/dsdc_drive_if.sv
`timescale 1ns/1ps
// Links the command logic with the stop sequencer.
interface dsdc_drive_if;
    logic run;
    logic [15:0] freq_cmd;
    logic [15:0] min_freq;
    logic [15:0] decel_step;
    logic [15:0] method;
    logic tick;
    logic pos_done;
    logic [15:0] out_freq;
    logic out_en;
    logic pos_start;
    logic running;
    modport ctl (output run, freq_cmd, min_freq, decel_step, method, tick, pos_done,
        input out_freq, out_en, pos_start, running);
    modport seq (input run, freq_cmd, min_freq, decel_step, method, tick, pos_done,
        output out_freq, out_en, pos_start, running);
endinterface

// File: src/dsdc_tick_div.sv
`timescale 1ns/1ps
// Divides pclk into a one-cycle deceleration tick.
module dsdc_tick_div #(
    parameter int DIV = 100000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    initial begin
        if (DIV < 1) begin
            $error("DIV must be at least one.");
        end
    end
    logic [31:0] cnt;
    // Counts up and pulses on wrap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(DIV - 1)) begin
            cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// File: src/dsdc_stop_seq.sv
`timescale 1ns/1ps
// Runs the output and carries out the selected stop method.
module dsdc_stop_seq (
    input wire logic pclk,
    input wire logic presetn,
    dsdc_drive_if.seq d
);
    dsdc_pkg::dsdc_stop_state_t state;
    assign d.running = (state != dsdc_pkg::DSDC_IDLE);
    // Sequencer for run, ramp, coast and positioning stop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dsdc_pkg::DSDC_IDLE;
            d.out_freq <= 16'h0;
            d.out_en <= 1'b0;
            d.pos_start <= 1'b0;
        end else begin
            d.pos_start <= 1'b0;
            unique case (state)
                dsdc_pkg::DSDC_IDLE, dsdc_pkg::DSDC_RUN: begin
                    if (d.run) begin
                        state <= dsdc_pkg::DSDC_RUN;
                        d.out_freq <= d.freq_cmd;
                        d.out_en <= 1'b1;
                    end else if (state == dsdc_pkg::DSDC_RUN) begin
                        if (d.method == dsdc_pkg::STOP_COAST) begin
                            state <= dsdc_pkg::DSDC_IDLE;
                            d.out_en <= 1'b0;
                            d.out_freq <= 16'h0;
                        end else if (d.method == dsdc_pkg::STOP_POSN) begin
                            state <= dsdc_pkg::DSDC_POSN;
                            d.pos_start <= 1'b1;
                        end else begin
                            state <= dsdc_pkg::DSDC_RAMP;
                        end
                    end
                end
                dsdc_pkg::DSDC_RAMP: begin
                    if (d.run) begin
                        state <= dsdc_pkg::DSDC_RUN;
                        d.out_freq <= d.freq_cmd;
                    end else if (d.tick) begin
                        if ({1'b0, d.out_freq} <= {1'b0, d.min_freq} + {1'b0, d.decel_step}) begin
                            state <= dsdc_pkg::DSDC_IDLE;
                            d.out_en <= 1'b0;
                            d.out_freq <= 16'h0;
                        end else begin
                            d.out_freq <= d.out_freq - d.decel_step;
                        end
                    end
                end
                dsdc_pkg::DSDC_POSN: begin
                    if (d.pos_done) begin
                        state <= dsdc_pkg::DSDC_IDLE;
                        d.out_en <= 1'b0;
                        d.out_freq <= 16'h0;
                    end
                end
                default: begin
                    state <= dsdc_pkg::DSDC_IDLE;
                    d.out_en <= 1'b0;
                    d.out_freq <= 16'h0;
                end
            endcase
        end
    end
endmodule

// File: src/dsdc_top.sv
`timescale 1ns/1ps
// Stop, direction and display configuration block with APB access.
module dsdc_top #(
    parameter int DECEL_TICK_CYCLES = dsdc_pkg::DECEL_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic remote_mode,
    input wire logic [2:0] run_req,
    input wire logic [2:0] rev_req,
    input wire logic [2:0] jog_req,
    input wire logic multi_function_input_41,
    input wire logic multi_function_input_42,
    input wire logic keypad_mode_switch_req,
    input wire logic [15:0] freq_cmd,
    input wire logic [15:0] max_operating_freq,
    input wire logic [15:0] min_output_freq,
    input wire logic [15:0] decel_step,
    input wire logic undervoltage_event,
    input wire logic fault_event,
    input wire logic positioning_done,
    output logic [15:0] output_freq,
    output logic output_enable,
    output logic output_reverse,
    output logic positioning_start,
    output logic jog_valid,
    output logic mode_switch_grant,
    output logic [15:0] user_scaled_value,
    output logic user_value_valid
);
    initial begin
        if (DECEL_TICK_CYCLES < 1) begin
            $error("DECEL_TICK_CYCLES must be at least one.");
        end
    end

    // ******
    // Parameter registers
    // ******
    logic [15:0] auto_freq_source;
    logic [15:0] auto_run_cmd_source;
    logic [15:0] stop_method_select;
    logic [15:0] direction_inhibit;
    logic [15:0] keypad_freq_latch;
    logic [15:0] display_unit_format;
    logic [15:0] user_scale_maximum;
    logic [15:0] local_remote_policy;
    logic [15:0] wdat;
    logic [9:0] idx;
    logic wr_en;
    logic addr_hit;
    logic addr_ro;

    assign wdat = pwdata[15:0];
    assign idx = paddr[11:2];
    assign wr_en = psel && penable && pwrite;

    // Decodes which word the bus points at.
    always_comb begin
        addr_hit = 1'b1;
        addr_ro = 1'b0;
        unique case (idx)
            dsdc_pkg::IDX_FREQ_SRC, dsdc_pkg::IDX_RUN_SRC, dsdc_pkg::IDX_STOP,
            dsdc_pkg::IDX_DIR, dsdc_pkg::IDX_FORMAT, dsdc_pkg::IDX_USER_MAX,
            dsdc_pkg::IDX_POLICY: begin
                addr_ro = 1'b0;
            end
            dsdc_pkg::IDX_KP_LATCH, dsdc_pkg::IDX_USER_VAL, dsdc_pkg::IDX_STATUS: begin
                addr_ro = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            addr_hit = 1'b0;
        end
    end

    // Zero wait state slave; errors on any unmapped access or a read-only write.
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_hit || (pwrite && addr_ro));

    // Frequency source accepts only its defined codes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_freq_source <= dsdc_pkg::RST_FREQ_SRC;
        end else if (wr_en && addr_hit && idx == dsdc_pkg::IDX_FREQ_SRC &&
            (wdat <= 16'h0004 || wdat == 16'h0007 || wdat == 16'h0009)) begin
            auto_freq_source <= wdat;
        end
    end

    // Enumerated fields each keep their value on an illegal code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_run_cmd_source <= dsdc_pkg::RST_RUN_SRC;
            stop_method_select <= dsdc_pkg::RST_STOP;
            direction_inhibit <= dsdc_pkg::RST_DIR;
            local_remote_policy <= dsdc_pkg::RST_POLICY;
        end else if (wr_en && addr_hit) begin
            if (idx == dsdc_pkg::IDX_RUN_SRC && wdat <= dsdc_pkg::RUN_SRC_MAX) begin
                auto_run_cmd_source <= wdat;
            end
            if (idx == dsdc_pkg::IDX_STOP && wdat <= dsdc_pkg::STOP_POSN) begin
                stop_method_select <= wdat;
            end
            if (idx == dsdc_pkg::IDX_DIR && wdat <= dsdc_pkg::DIR_NO_FWD) begin
                direction_inhibit <= wdat;
            end
            if (idx == dsdc_pkg::IDX_POLICY && wdat <= dsdc_pkg::POLICY_MAX) begin
                local_remote_policy <= wdat;
            end
        end
    end

    // Display format; decimal places beyond three are refused.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_unit_format <= dsdc_pkg::RST_FORMAT;
        end else if (wr_en && addr_hit && idx == dsdc_pkg::IDX_FORMAT &&
            wdat[dsdc_pkg::FMT_DEC_MSB:dsdc_pkg::FMT_DEC_LSB] <= dsdc_pkg::FMT_DEC_MAX) begin
            display_unit_format <= wdat;
        end
    end

    // User maximum takes any 16-bit value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_scale_maximum <= dsdc_pkg::RST_USER_MAX;
        end else if (wr_en && addr_hit && idx == dsdc_pkg::IDX_USER_MAX) begin
            user_scale_maximum <= wdat;
        end
    end

    // ******
    // Keypad frequency memory
    // ******
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keypad_freq_latch <= 16'h0;
        end else if ((undervoltage_event || fault_event) &&
            auto_freq_source == dsdc_pkg::SRC_KEYPAD) begin
            keypad_freq_latch <= freq_cmd;
        end
    end

    // ******
    // Command selection
    // ******
    logic [1:0] src;
    logic sel_run;
    logic sel_rev;
    logic sel_jog;
    logic cmd_blocked;
    logic dir_ok;
    logic run_go;
    logic rev_hold;

    assign src = remote_mode ? auto_run_cmd_source[1:0] : 2'd0;
    assign sel_run = run_req[src];
    assign sel_rev = rev_req[src];
    assign sel_jog = jog_req[src];
    assign cmd_blocked = (local_remote_policy == dsdc_pkg::POLICY_HOA) &&
        !multi_function_input_41 && !multi_function_input_42;
    assign dir_ok = sel_rev ? (direction_inhibit != dsdc_pkg::DIR_NO_REV) :
        (direction_inhibit != dsdc_pkg::DIR_NO_FWD);
    assign run_go = (sel_run || sel_jog) && !cmd_blocked && dir_ok;
    assign jog_valid = sel_jog && !cmd_blocked && dir_ok;
    assign mode_switch_grant = keypad_mode_switch_req &&
        (auto_run_cmd_source != dsdc_pkg::SRC_KEYPAD);

    // Direction follows the selected reverse request while run_go is high and holds otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rev_hold <= 1'b0;
        end else if (run_go) begin
            rev_hold <= sel_rev;
        end
    end
    assign output_reverse = rev_hold;

    // ******
    // Stop sequencer and tick
    // ******
    dsdc_drive_if drv ();
    logic tick;

    dsdc_tick_div #(
        .DIV(DECEL_TICK_CYCLES)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign drv.run = run_go;
    assign drv.freq_cmd = freq_cmd;
    assign drv.min_freq = min_output_freq;
    assign drv.decel_step = decel_step;
    assign drv.method = stop_method_select;
    assign drv.tick = tick;
    assign drv.pos_done = positioning_done;

    dsdc_stop_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .d(drv.seq)
    );

    assign output_freq = drv.out_freq;
    assign output_enable = drv.out_en;
    assign positioning_start = drv.pos_start;

    // ******
    // User-scaled display value
    // ******
    logic [31:0] scaled_prod;
    logic [31:0] scaled_quot;

    assign scaled_prod = {16'h0, output_freq} * {16'h0, user_scale_maximum};
    assign scaled_quot = (max_operating_freq == 16'h0) ? 32'h0 :
        scaled_prod / {16'h0, max_operating_freq};

    // Scaled value refreshed every cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_scaled_value <= 16'h0;
            user_value_valid <= 1'b0;
        end else begin
            user_scaled_value <= scaled_quot[15:0];
            user_value_valid <= (user_scale_maximum != 16'h0) &&
                (auto_freq_source == dsdc_pkg::SRC_KEYPAD ||
                auto_freq_source == dsdc_pkg::SRC_SERIAL_FREQ);
        end
    end

    // ******
    // Read mux
    // ******
    always_comb begin
        prdata = 32'h0;
        if (psel && !pwrite && addr_hit) begin
            unique case (idx)
                dsdc_pkg::IDX_FREQ_SRC: prdata = {16'h0, auto_freq_source};
                dsdc_pkg::IDX_RUN_SRC: prdata = {16'h0, auto_run_cmd_source};
                dsdc_pkg::IDX_STOP: prdata = {16'h0, stop_method_select};
                dsdc_pkg::IDX_DIR: prdata = {16'h0, direction_inhibit};
                dsdc_pkg::IDX_KP_LATCH: prdata = {16'h0, keypad_freq_latch};
                dsdc_pkg::IDX_FORMAT: prdata = {16'h0, display_unit_format};
                dsdc_pkg::IDX_USER_MAX: prdata = {16'h0, user_scale_maximum};
                dsdc_pkg::IDX_USER_VAL: begin
                    prdata = user_value_valid ? {16'h0, user_scaled_value} : 32'h0;
                end
                dsdc_pkg::IDX_POLICY: prdata = {16'h0, local_remote_policy};
                dsdc_pkg::IDX_STATUS: begin
                    prdata = {27'h0, drv.running, cmd_blocked, rev_hold,
                        positioning_start, output_enable};
                end
                default: prdata = 32'h0;
            endcase
        end
    end
endmodule

// File: tb/dsdc_props.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
// Watches the bus and drive outputs.
module dsdc_props #(
    parameter int DECEL_TICK_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] run_req,
    input wire logic [2:0] jog_req,
    input wire logic multi_function_input_41,
    input wire logic multi_function_input_42,
    input wire logic keypad_mode_switch_req,
    input wire logic [15:0] output_freq,
    input wire logic output_enable,
    input wire logic output_reverse,
    input wire logic positioning_start,
    input wire logic jog_valid,
    input wire logic mode_switch_grant,
    input wire logic user_value_valid
);
    logic w;
    logic [15:0] src_sh, stop_sh, dir_sh, pol_sh, max_sh;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadows of accepted writes.
    assign w = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sh <= 16'h0000;
            stop_sh <= 16'h0000;
            dir_sh <= 16'h0000;
            max_sh <= 16'h0000;
            pol_sh <= dsdc_pkg::RST_POLICY;
        end else if (w) begin
            if (paddr == 12'h054 && pwdata[15:0] <= 16'h0002) src_sh <= pwdata[15:0];
            if (paddr == 12'h058 && pwdata[15:0] <= 16'h0002) stop_sh <= pwdata[15:0];
            if (paddr == 12'h05c && pwdata[15:0] <= 16'h0002) dir_sh <= pwdata[15:0];
            if (paddr == 12'h074 && pwdata[15:0] <= 16'h0004) pol_sh <= pwdata[15:0];
            if (paddr == 12'h068) max_sh <= pwdata[15:0];
        end
    end
    a_ro_refused: assert property (
        psel && penable && pwrite && paddr == 12'h060 |-> pslverr)
        else $error("write to latch not refused");
    a_upper_zero: assert property (
        psel && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_dir_blocked: assert property (
        $rose(output_enable) |-> $past(dir_sh) != (output_reverse ? 16'h0001 : 16'h0002))
        else $error("run started in a blocked direction");
    a_coast_drop: assert property (
        stop_sh == 16'h0001 && run_req == 3'h0 && jog_req == 3'h0 && output_enable
        |=> !output_enable && output_freq == 16'h0000)
        else $error("coast stop kept output");
    a_stop_no_rise: assert property (
        output_enable && run_req == 3'h0 && jog_req == 3'h0 && $past(run_req) == 3'h0
        && $past(jog_req) == 3'h0 |-> output_freq <= $past(output_freq))
        else $error("frequency rose while stopping");
    a_pos_pulse: assert property (
        positioning_start |-> output_enable && $past(stop_sh) == 16'h0002 ##1 !positioning_start)
        else $error("bad positioning start pulse");
    a_scale_off: assert property (
        max_sh == 16'h0000 && $past(max_sh) == 16'h0000 && $past(max_sh, 2) == 16'h0000
        |-> !user_value_valid)
        else $error("scaled value valid with zero maximum");
    a_grant_match: assert property (
        mode_switch_grant == (keypad_mode_switch_req && src_sh != 16'h0000))
        else $error("mode switch grant wrong");
    a_jog_blocked: assert property (
        pol_sh == 16'h0000 && !multi_function_input_41 && !multi_function_input_42 |-> !jog_valid)
        else $error("jog accepted while blocked");
    c_stop: cover property ($fell(output_enable));
    c_posn: cover property (positioning_start);
    c_err: cover property (penable && pslverr);
endmodule
bind dsdc_top dsdc_props #(.DECEL_TICK_CYCLES(DECEL_TICK_CYCLES)) u_props (.*);

// File: tb/dsdc_host.sv
`timescale 1ns/1ps
// ****
// Register host
// ****
// Host side of the register bus, one APB transfer per call.
module dsdc_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int hangs = 0;
    // The bus starts idle.
    initial begin
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // Setup cycle, then access held until pready is seen at an edge.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hangs++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// File: tb/test_drive_stop_direction_display_cfg.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_drive_stop_direction_display_cfg;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, remote_mode;
    logic keypad_mode_switch_req, multi_function_input_41, multi_function_input_42;
    logic undervoltage_event, fault_event, positioning_done, output_enable, output_reverse;
    logic positioning_start, jog_valid, mode_switch_grant, user_value_valid;
    logic [2:0] run_req, rev_req, jog_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] freq_cmd, max_operating_freq, min_output_freq, decel_step, output_freq;
    logic [15:0] user_scaled_value, v, f, lat;
    logic [15:0] sh[5];
    logic [9:0] ix[5];
    int n_errors = 0;
    int checked = 0;
    int i, k;
    dsdc_top #(.DECEL_TICK_CYCLES(4)) uut (.*);
    dsdc_host host (.*);
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [9:0] idx, input logic [15:0] d);
        host.xfer(wr, {idx, 2'b00}, {16'h0000, d}, q, e);
        if (host.hangs != 0) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
        acc(1'b0, idx, 16'h0000);
        chk("register", {16'h0000, exp}, q);
    endtask
    task automatic wait_en(input logic lvl);
        int n;
        for (n = 0; n < 300 && output_enable !== lvl; n++) begin
            @(negedge pclk);
        end
        if (n == 300) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic run_at(input logic [2:0] r, input logic [15:0] fr);
        @(posedge pclk);
        run_req <= r;
        freq_cmd <= fr;
        wait_en(1'b1);
    endtask
    task automatic halt();
        @(posedge pclk);
        run_req <= 3'h0;
        jog_req <= 3'h0;
    endtask
    // Expected content after a write: illegal codes keep the old value.
    function automatic logic [15:0] nxt(int n, logic [15:0] d, logic [15:0] old);
        if (n == 4) return d;
        if (n == 3) return (d[3:0] <= dsdc_pkg::FMT_DEC_MAX) ? d : old;
        return (d <= 16'h0002) ? d : old;
    endfunction
    function automatic logic [15:0] scale(logic [15:0] fr, logic [15:0] u);
        return 16'((32'(fr) * 32'(u)) / 32'h00001770);
    endfunction
    // Clock and watchdog.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #500000;
        n_errors++;
        stop_test();
    end
    // Main sequence.
    initial begin
        {presetn, remote_mode, keypad_mode_switch_req} = 3'b000;
        {multi_function_input_41, multi_function_input_42, positioning_done} = 3'b000;
        {undervoltage_event, fault_event, run_req, rev_req, jog_req} = 11'h000;
        {freq_cmd, min_output_freq, decel_step} = {16'h0000, 16'h0014, 16'h000a};
        max_operating_freq = 16'h1770;
        sh = '{default: 16'h0000};
        ix = '{dsdc_pkg::IDX_RUN_SRC, dsdc_pkg::IDX_STOP, dsdc_pkg::IDX_DIR,
            dsdc_pkg::IDX_FORMAT, dsdc_pkg::IDX_USER_MAX};
        k = $urandom(32'hb3c136e5);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) rd(ix[i], 16'h0000);
        rd(dsdc_pkg::IDX_POLICY, dsdc_pkg::RST_POLICY);
        acc(1'b1, dsdc_pkg::IDX_KP_LATCH, 16'h1234);
        chk("ro error", 1, e);
        acc(1'b0, 10'h01f, 16'h0000);
        chk("unmapped error", 1, e);
        rd(dsdc_pkg::IDX_KP_LATCH, 16'h0000);
        acc(1'b1, ix[3], 16'h01a3);
        rd(ix[3], 16'h01a3);
        for (i = 0; i < 40; i++) begin
            k = i % 5;
            v = 16'($urandom);
            if (k < 3) v = v % 16'h0005;
            if (k == 3) v[3:0] = v[3:0] % 4'h6;
            acc(1'b1, ix[k], v);
            sh[k] = nxt(k, v, sh[k]);
            rd(ix[k], sh[k]);
        end
        acc(1'b1, ix[0], 16'h0000);
        acc(1'b1, ix[2], 16'h0000);
        acc(1'b1, ix[1], dsdc_pkg::STOP_RAMP);
        run_at(3'b001, 16'h0064);
        chk("freq", 16'h0064, output_freq);
        rd(dsdc_pkg::IDX_STATUS, 16'h0011);
        halt();
        repeat (2) @(negedge pclk);
        chk("ramp enable", 1, output_enable);
        wait_en(1'b0);
        chk("ramp freq", 0, output_freq);
        acc(1'b1, ix[1], dsdc_pkg::STOP_POSN);
        run_at(3'b001, 16'h012c);
        halt();
        for (k = 0; k < 8 && positioning_start !== 1'b1; k++) @(negedge pclk);
        chk("posn start", 1, positioning_start);
        repeat (20) @(negedge pclk);
        chk("posn hold", 1, output_enable);
        @(posedge pclk);
        positioning_done <= 1'b1;
        wait_en(1'b0);
        @(posedge pclk);
        positioning_done <= 1'b0;
        acc(1'b1, ix[1], dsdc_pkg::STOP_COAST);
        for (i = 0; i < 6; i++) begin
            acc(1'b1, ix[2], 16'(i / 2));
            @(posedge pclk);
            rev_req <= {2'b00, i[0]};
            run_req <= 3'b001;
            repeat (4) @(negedge pclk);
            chk("enable", (i / 2) != 2 - (i % 2), output_enable);
            if (output_enable === 1'b1) chk("reverse", i % 2, output_reverse);
            halt();
            repeat (2) @(negedge pclk);
            chk("coast", 0, {output_enable, output_freq});
        end
        acc(1'b1, ix[2], 16'h0000);
        @(posedge pclk);
        remote_mode <= 1'b1;
        acc(1'b1, ix[0], 16'h0002);
        @(posedge pclk);
        run_req <= 3'b011;
        repeat (4) @(negedge pclk);
        chk("auto source", 0, output_enable);
        run_at(3'b100, 16'h00c8);
        halt();
        wait_en(1'b0);
        remote_mode <= 1'b0;
        keypad_mode_switch_req <= 1'b1;
        @(negedge pclk);
        chk("grant", 1, mode_switch_grant);
        acc(1'b1, ix[0], 16'h0000);
        @(negedge pclk);
        chk("grant", 0, mode_switch_grant);
        acc(1'b1, dsdc_pkg::IDX_POLICY, dsdc_pkg::POLICY_HOA);
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            {multi_function_input_42, multi_function_input_41} <= i[1:0];
            jog_req <= 3'b001;
            run_req <= 3'b001;
            repeat (4) @(negedge pclk);
            chk("jog", i != 0, jog_valid);
            chk("run", i != 0, output_enable);
            halt();
            wait_en(1'b0);
        end
        for (i = 0; i < 3; i++) begin
            acc(1'b1, dsdc_pkg::IDX_FREQ_SRC, 16'(i / 2));
            v = 16'($urandom);
            if (i < 2) lat = v;
            @(posedge pclk);
            freq_cmd <= v;
            undervoltage_event <= (i == 0);
            fault_event <= (i != 0);
            @(posedge pclk);
            {undervoltage_event, fault_event} <= 2'b00;
            rd(dsdc_pkg::IDX_KP_LATCH, lat);
        end
        for (i = 0; i < 5; i++) begin
            sh[4] = (i < 4) ? 16'($urandom) : 16'h0000;
            acc(1'b1, ix[4], sh[4]);
            acc(1'b1, dsdc_pkg::IDX_FREQ_SRC, 16'((i == 4) ? 0 : i));
            f = 16'($urandom_range(6000, 1));
            run_at(3'b001, f);
            repeat (3) @(negedge pclk);
            chk("valid", i < 2, user_value_valid);
            if (i < 4) chk("scaled", scale(f, sh[4]), user_scaled_value);
            rd(dsdc_pkg::IDX_USER_VAL, (i < 2) ? scale(f, sh[4]) : 16'h0000);
            halt();
            wait_en(1'b0);
        end
        stop_test();
    end
endmodule
